// ===== ivfh_pkg.sv
package ivfh_pkg;
    // ------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_OV_WARN = 8'h57;   // input overvolt warn threshold
    localparam logic [7:0] CMD_UV_WARN = 8'h58;   // input undervolt warn threshold
    localparam logic [7:0] CMD_UV_FAULT = 8'h59;  // input undervolt fault threshold
    localparam logic [7:0] CMD_UV_ACTION = 8'h5A; // undervolt fault action byte
    localparam logic [7:0] CMD_SPECIAL = 8'hE0;   // special options command
    localparam logic [7:0] CMD_TIME_UNIT = 8'hD2; // delay time unit register

    // ------------------------------------------------------------
    // field layout of the action byte and the special options byte
    // ------------------------------------------------------------
    localparam int RESP_HI = 7;   // response field top bit
    localparam int RESP_LO = 6;   // response field low bit
    localparam int RETRY_HI = 5;  // retry field top bit
    localparam int RETRY_LO = 3;  // retry field low bit
    localparam int DELAY_HI = 2;  // delay field top bit
    localparam int HRR_EN_BIT = 0; // ratio regulation enable in special options

    localparam logic [1:0] RESP_IGNORE = 2'h0;  // keep running
    localparam logic [1:0] RESP_DELAYED = 2'h1; // run for delay, then retry policy
    localparam logic [1:0] RESP_DISABLE = 2'h2; // disable then retry policy
    localparam logic [1:0] RESP_LATCH = 2'h3;   // latch off until cleared
    localparam logic [2:0] RETRY_NONE = 3'h0;   // no restart attempts
    localparam logic [2:0] RETRY_FOREVER = 3'h7; // unlimited restarts

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_THRESH = 16'h0000; // thresholds after reset
    localparam logic [7:0] RST_ACTION = 8'h00;     // action byte after reset
    localparam logic [7:0] RST_SPECIAL = 8'h00;    // special options after reset
    localparam logic [15:0] RST_TIME_UNIT = 16'h0001; // cycles per delay unit

    typedef enum logic [2:0] {
        IVFH_RUN,      // output enabled, no fault handling pending
        IVFH_DELAY,    // fault seen, still running for the delay
        IVFH_WAIT,     // output off, waiting before a restart
        IVFH_RESTART,  // output on again, checking the fault
        IVFH_LATCHED   // output off until the fault is cleared
    } ivfh_state_t;
endpackage

// ===== ivfh_core.sv
`timescale 1ns/1ps
module ivfh_core
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic cmd_wr,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    input wire logic [7:0] cmd_rcode,
    input wire logic [15:0] vin_sample,
    input wire logic vin_valid,
    input wire logic clear_faults,
    input wire logic output_on_cmd,
    output logic [15:0] cmd_rdata_ff,
    output logic output_enable_ff,
    output logic ov_warn_ff,
    output logic uv_warn_ff,
    output logic uv_fault_ff,
    output logic hrr_low_ff
);
    // ------------------------------------------------------------
    // linear decode: value = mantissa * 2^exp, scaled to 1/65536 V
    // ------------------------------------------------------------
    function automatic logic signed [63:0] lin_val(input logic [15:0] w);
        logic signed [4:0] e;
        logic signed [63:0] m;
        e = w[15:11];
        m = 64'(signed'(w[10:0]));
        // the exponent is never below -16, so the shift count cannot go negative
        lin_val = m <<< (16 + e);
    endfunction

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [15:0] ov_warn_thr_ff, nxt_ov_warn_thr;    // input_overvolt_warn_threshold
    logic [15:0] uv_warn_thr_ff, nxt_uv_warn_thr;    // input_undervolt_warn_threshold
    logic [15:0] uv_fault_thr_ff, nxt_uv_fault_thr;  // input_undervolt_fault_threshold
    logic [7:0] uv_action_ff, nxt_uv_action;         // input_undervolt_fault_action
    logic [7:0] special_ff, nxt_special;             // special_options_command
    logic [15:0] time_unit_ff, nxt_time_unit;        // cycles per delay unit
    logic [15:0] nxt_rdata;

    // write decode and read mux
    // unused codes fall through, so a host probing them cannot disturb
    // the limits; reads of them return zero rather than stale data
    always_comb
    begin
        nxt_ov_warn_thr = ov_warn_thr_ff;
        nxt_uv_warn_thr = uv_warn_thr_ff;
        nxt_uv_fault_thr = uv_fault_thr_ff;
        nxt_uv_action = uv_action_ff;
        nxt_special = special_ff;
        nxt_time_unit = time_unit_ff;
        if (cmd_wr)
        begin
            unique case (cmd_code)
                ivfh_pkg::CMD_OV_WARN: nxt_ov_warn_thr = cmd_wdata;
                ivfh_pkg::CMD_UV_WARN: nxt_uv_warn_thr = cmd_wdata;
                ivfh_pkg::CMD_UV_FAULT: nxt_uv_fault_thr = cmd_wdata;
                ivfh_pkg::CMD_UV_ACTION: nxt_uv_action = cmd_wdata[7:0];
                ivfh_pkg::CMD_SPECIAL: nxt_special = cmd_wdata[7:0];
                ivfh_pkg::CMD_TIME_UNIT: nxt_time_unit = cmd_wdata;
                default: ;  // unknown codes are ignored
            endcase
        end
        unique case (cmd_rcode)
            ivfh_pkg::CMD_OV_WARN: nxt_rdata = ov_warn_thr_ff;
            ivfh_pkg::CMD_UV_WARN: nxt_rdata = uv_warn_thr_ff;
            ivfh_pkg::CMD_UV_FAULT: nxt_rdata = uv_fault_thr_ff;
            ivfh_pkg::CMD_UV_ACTION: nxt_rdata = {8'h00, uv_action_ff};
            ivfh_pkg::CMD_SPECIAL: nxt_rdata = {8'h00, special_ff};
            ivfh_pkg::CMD_TIME_UNIT: nxt_rdata = time_unit_ff;
            default: nxt_rdata = 16'h0000;  // unmapped reads as zero
        endcase
    end

    // register state
    // the read word is registered, so a read answers one cycle after its code
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            ov_warn_thr_ff <= ivfh_pkg::RST_THRESH;
            uv_warn_thr_ff <= ivfh_pkg::RST_THRESH;
            uv_fault_thr_ff <= ivfh_pkg::RST_THRESH;
            uv_action_ff <= ivfh_pkg::RST_ACTION;
            special_ff <= ivfh_pkg::RST_SPECIAL;
            time_unit_ff <= ivfh_pkg::RST_TIME_UNIT;
            cmd_rdata_ff <= 16'h0000;
        end
        else
        begin
            ov_warn_thr_ff <= nxt_ov_warn_thr;
            uv_warn_thr_ff <= nxt_uv_warn_thr;
            uv_fault_thr_ff <= nxt_uv_fault_thr;
            uv_action_ff <= nxt_uv_action;
            special_ff <= nxt_special;
            time_unit_ff <= nxt_time_unit;
            cmd_rdata_ff <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------
    // sample comparison
    // ------------------------------------------------------------
    logic [15:0] sample_s1_ff, sample_s2_ff; // two-flop capture of the pin sample
    logic valid_s1_ff, valid_s2_ff;          // sample strobe synchroniser
    logic valid_d_ff;                        // edge detect on synchronised strobe
    logic uv_now_ff, nxt_uv_now;             // fault condition from last sample
    logic nxt_ov_warn, nxt_uv_warn, nxt_uv_fault, nxt_hrr_low;
    logic signed [63:0] vin_v;

    // compare a fresh sample; sticky flags hold until cleared, set wins
    // the word is read only on the strobe's synchronised rising edge, by
    // which time its own two-flop copy has settled
    always_comb
    begin
        vin_v = lin_val(sample_s2_ff);
        nxt_uv_now = uv_now_ff;
        nxt_ov_warn = ov_warn_ff & ~clear_faults;
        nxt_uv_warn = uv_warn_ff & ~clear_faults;
        nxt_uv_fault = uv_fault_ff & ~clear_faults;
        nxt_hrr_low = hrr_low_ff;
        if (valid_s2_ff && !valid_d_ff)
        begin
            nxt_uv_now = vin_v < lin_val(uv_fault_thr_ff);
            if (vin_v > lin_val(ov_warn_thr_ff)) nxt_ov_warn = 1'b1;
            if (vin_v < lin_val(uv_warn_thr_ff)) nxt_uv_warn = 1'b1;
            if (vin_v < lin_val(uv_fault_thr_ff)) nxt_uv_fault = 1'b1;
            // ratio regulation engages below the warn threshold only if enabled
            nxt_hrr_low = special_ff[ivfh_pkg::HRR_EN_BIT]
                        && (vin_v < lin_val(uv_warn_thr_ff));
        end
        if (!special_ff[ivfh_pkg::HRR_EN_BIT]) nxt_hrr_low = 1'b0;
    end

    // sample capture and flag registers
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            sample_s1_ff <= 16'h0000;
            sample_s2_ff <= 16'h0000;
            valid_s1_ff <= 1'b0;
            valid_s2_ff <= 1'b0;
            valid_d_ff <= 1'b0;
            uv_now_ff <= 1'b0;
            ov_warn_ff <= 1'b0;
            uv_warn_ff <= 1'b0;
            uv_fault_ff <= 1'b0;
            hrr_low_ff <= 1'b0;
        end
        else
        begin
            sample_s1_ff <= vin_sample;
            sample_s2_ff <= sample_s1_ff;
            valid_s1_ff <= vin_valid;
            valid_s2_ff <= valid_s1_ff;
            valid_d_ff <= valid_s2_ff;
            uv_now_ff <= nxt_uv_now;
            ov_warn_ff <= nxt_ov_warn;
            uv_warn_ff <= nxt_uv_warn;
            uv_fault_ff <= nxt_uv_fault;
            hrr_low_ff <= nxt_hrr_low;
        end
    end

    // ------------------------------------------------------------
    // fault response sequencer
    // ------------------------------------------------------------
    ivfh_pkg::ivfh_state_t st_ff, nxt_st;
    logic [23:0] tmr_ff, nxt_tmr;   // delay countdown in cycles
    logic [2:0] tries_ff, nxt_tries; // restarts used so far
    logic on_d_ff;                   // previous output-on command, for off-on edge
    logic nxt_oe;
    logic [1:0] resp;
    logic [2:0] retry;
    logic [23:0] delay_cyc;
    logic off_on;

    // delay length: unit cycles shifted by the delay code
    // trade-off: a 24-bit timer holds the largest unit times 128 exactly
    always_comb
    begin
        resp = uv_action_ff[ivfh_pkg::RESP_HI:ivfh_pkg::RESP_LO];
        retry = uv_action_ff[ivfh_pkg::RETRY_HI:ivfh_pkg::RETRY_LO];
        delay_cyc = 24'(time_unit_ff) << uv_action_ff[ivfh_pkg::DELAY_HI:0];
        off_on = output_on_cmd && !on_d_ff;
        nxt_st = st_ff;
        nxt_tmr = (tmr_ff != 24'h0) ? tmr_ff - 24'h1 : tmr_ff;
        nxt_tries = tries_ff;
        unique case (st_ff)
            ivfh_pkg::IVFH_RUN:
            begin
                nxt_tries = 3'h0;
                if (uv_now_ff)
                begin
                    unique case (resp)
                        ivfh_pkg::RESP_IGNORE: nxt_st = ivfh_pkg::IVFH_RUN;
                        ivfh_pkg::RESP_DELAYED:
                        begin
                            nxt_st = ivfh_pkg::IVFH_DELAY;
                            nxt_tmr = delay_cyc;
                        end
                        ivfh_pkg::RESP_DISABLE:
                        begin
                            nxt_st = (retry == ivfh_pkg::RETRY_NONE)
                                   ? ivfh_pkg::IVFH_LATCHED : ivfh_pkg::IVFH_WAIT;
                            nxt_tmr = delay_cyc;
                        end
                        ivfh_pkg::RESP_LATCH: nxt_st = ivfh_pkg::IVFH_LATCHED;
                    endcase
                end
            end
            ivfh_pkg::IVFH_DELAY:
            begin
                if (!uv_now_ff) nxt_st = ivfh_pkg::IVFH_RUN;
                else if (tmr_ff == 24'h0)
                begin
                    nxt_st = (retry == ivfh_pkg::RETRY_NONE)
                           ? ivfh_pkg::IVFH_LATCHED : ivfh_pkg::IVFH_WAIT;
                    nxt_tmr = delay_cyc;
                end
            end
            ivfh_pkg::IVFH_WAIT:
            begin
                if (tmr_ff == 24'h0)
                begin
                    nxt_st = ivfh_pkg::IVFH_RESTART;
                    nxt_tmr = delay_cyc;
                    if (retry != ivfh_pkg::RETRY_FOREVER)
                        nxt_tries = tries_ff + 3'h1;
                end
            end
            ivfh_pkg::IVFH_RESTART:
            begin
                if (!uv_now_ff && tmr_ff == 24'h0) nxt_st = ivfh_pkg::IVFH_RUN;
                else if (uv_now_ff)
                begin
                    // exhausted attempts stay off until cleared
                    if (retry != ivfh_pkg::RETRY_FOREVER && tries_ff >= retry)
                        nxt_st = ivfh_pkg::IVFH_LATCHED;
                    else
                    begin
                        nxt_st = ivfh_pkg::IVFH_WAIT;
                        // the restart cycle and the reload cycle come off the wait,
                        // so attempts start exactly one delay apart; a one-cycle
                        // delay still spaces them two cycles apart
                        nxt_tmr = (delay_cyc > 24'h2) ? delay_cyc - 24'h2 : 24'h0;
                    end
                end
            end
            ivfh_pkg::IVFH_LATCHED:
            begin
                if (clear_faults || off_on) nxt_st = ivfh_pkg::IVFH_RUN;
            end
        endcase
        // commanded off overrides everything, including unlimited retries
        if (!output_on_cmd)
            nxt_st = ivfh_pkg::IVFH_LATCHED;
        nxt_oe = (nxt_st == ivfh_pkg::IVFH_RUN) || (nxt_st == ivfh_pkg::IVFH_DELAY)
               || (nxt_st == ivfh_pkg::IVFH_RESTART);
    end

    // sequencer state
    // the enable follows the next state, so it drops on the very edge
    // that sees the fault and carries no decode glitch to the pin
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            st_ff <= ivfh_pkg::IVFH_LATCHED;
            tmr_ff <= 24'h000000;
            tries_ff <= 3'h0;
            on_d_ff <= 1'b0;
            output_enable_ff <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
            tmr_ff <= nxt_tmr;
            tries_ff <= nxt_tries;
            on_d_ff <= output_on_cmd;
            output_enable_ff <= nxt_oe;
        end
    end
endmodule

// ===== ivfh_core_properties.sv
`timescale 1ns/1ps
module ivfh_props
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic cmd_wr,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    input wire logic [7:0] cmd_rcode,
    input wire logic vin_valid,
    input wire logic clear_faults,
    input wire logic output_on_cmd,
    input wire logic [15:0] cmd_rdata_ff,
    input wire logic output_enable_ff,
    input wire logic ov_warn_ff,
    input wire logic uv_warn_ff,
    input wire logic uv_fault_ff
);
    logic [7:0] act_ff, nxt_act; // shadow of the action byte, seen from the write side
    logic known_rd; // read code names a register
    // ------------------------------------------------------------
    // write-side shadow: read data is what is under test, so not used here
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_act = sys_rst ? 8'h00 : act_ff;
        if (cmd_wr && cmd_code == ivfh_pkg::CMD_UV_ACTION)
            nxt_act = cmd_wdata[7:0];
        known_rd = cmd_rcode inside {8'h57, 8'h58, 8'h59, 8'h5A, 8'hE0, 8'hD2};
    end
    always_ff @(posedge clk_sys)
        act_ff <= nxt_act;
    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // written word shows on the read port two edges after the strobe
    property p_back(logic [7:0] c);
        cmd_wr && cmd_code == c ##1 (!cmd_wr && cmd_rcode == c)
            |=> cmd_rdata_ff == $past(cmd_wdata, 2);
    endproperty
    rd_unknown_a: assert property (!known_rd |=> cmd_rdata_ff == 16'h0000)
        else $error("unmapped read not zero");
    ov_readback_a: assert property (p_back(ivfh_pkg::CMD_OV_WARN))
        else $error("overvolt warn readback wrong");
    uvf_readback_a: assert property (p_back(ivfh_pkg::CMD_UV_FAULT))
        else $error("undervolt fault readback wrong");
    off_cmd_a: assert property (!output_on_cmd [*3] |-> !output_enable_ff)
        else $error("output on while commanded off");
    flag_clear_a: assert property ((clear_faults && !vin_valid) [*6]
        |-> !(ov_warn_ff || uv_warn_ff || uv_fault_ff))
        else $error("status flag survived clear");
    flag_cause_a: assert property ($rose(uv_fault_ff)
        |-> $past(vin_valid, 3) || $past(vin_valid, 4))
        else $error("fault flag without sample");
    ignore_keep_a: assert property (act_ff[7:6] == 2'h0 && output_enable_ff
        && output_on_cmd |=> output_enable_ff)
        else $error("output dropped in ignore mode");
    latch_hold_a: assert property ((act_ff[7:6] == 2'h3 && !output_enable_ff
        && output_on_cmd && !clear_faults) [*4] |=> !output_enable_ff)
        else $error("latched output came back");
    disable_fast_a: assert property ($rose(uv_fault_ff) && act_ff[7]
        |=> !output_enable_ff)
        else $error("output not disabled at fault");
    cover property ($fell(output_enable_ff) && act_ff[7:6] == 2'h1);
    cover property ($rose(output_enable_ff) && act_ff[5:3] != 3'h0);
    cover property ($rose(ov_warn_ff));
endmodule
bind ivfh_core ivfh_props u_props
(
    .clk_sys(clk_sys), .sys_rst(sys_rst), .cmd_wr(cmd_wr), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .cmd_rcode(cmd_rcode), .vin_valid(vin_valid),
    .clear_faults(clear_faults), .output_on_cmd(output_on_cmd), .cmd_rdata_ff(cmd_rdata_ff),
    .output_enable_ff(output_enable_ff), .ov_warn_ff(ov_warn_ff), .uv_warn_ff(uv_warn_ff),
    .uv_fault_ff(uv_fault_ff)
);

// ===== ivfh_host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// host on the command side; all changes at falling edges
// ------------------------------------------------------------
module ivfh_host_model
(
    input wire logic clk_sys,
    input wire logic [15:0] cmd_rdata_ff,
    output logic cmd_wr,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_wdata,
    output logic [7:0] cmd_rcode,
    output logic clear_faults,
    output logic output_on_cmd
);
    initial
    begin
        cmd_wr = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
        cmd_rcode = 8'h00;
        clear_faults = 1'b0;
        output_on_cmd = 1'b0;
    end
    // one-cycle strobe; released lines show the inverse, never the old word
    task automatic wr(input logic [7:0] code, input logic [15:0] data);
        @(negedge clk_sys);
        cmd_wr = 1'b1;
        cmd_code = code;
        cmd_wdata = data;
        @(negedge clk_sys);
        cmd_wr = 1'b0;
        cmd_code = ~code;
        cmd_wdata = ~data;
    endtask
    // read code taken at the next edge, answer one edge later
    task automatic rd(input logic [7:0] code, output logic [15:0] data);
        cmd_rcode = code;
        @(posedge clk_sys);
        @(negedge clk_sys);
        data = cmd_rdata_ff;
    endtask
    // on/off and clear levels, held long enough to be seen
    task automatic ctl(input logic on, input logic clr);
        @(negedge clk_sys);
        output_on_cmd = on;
        clear_faults = clr;
        repeat (6) @(negedge clk_sys);
    endtask
endmodule

// ===== input_voltage_fault_handler_tb_top.sv
`timescale 1ns/1ps
module input_voltage_fault_handler_tb_top;
    logic clk_sys, sys_rst, vin_valid, cmd_wr, clear_faults, output_on_cmd, oe_q;
    logic output_enable_ff, ov_warn_ff, uv_warn_ff, uv_fault_ff, hrr_low_ff;
    logic [7:0] cmd_code, cmd_rcode;
    logic [15:0] vin_sample, cmd_wdata, cmd_rdata_ff, rd_val;
    logic [31:0] rng;
    logic [7:0] codes [4] = '{8'h57, 8'h58, 8'h59, 8'h5A};
    int mismatches = 0, n_checks = 0, cyc = 0, rises = 0, gap = 0, last_rise = 0;
    ivfh_core u_dut
    (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .cmd_wr(cmd_wr), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .cmd_rcode(cmd_rcode), .vin_sample(vin_sample),
        .vin_valid(vin_valid), .clear_faults(clear_faults), .output_on_cmd(output_on_cmd),
        .cmd_rdata_ff(cmd_rdata_ff), .output_enable_ff(output_enable_ff),
        .ov_warn_ff(ov_warn_ff), .uv_warn_ff(uv_warn_ff), .uv_fault_ff(uv_fault_ff),
        .hrr_low_ff(hrr_low_ff)
    );
    ivfh_host_model u_host
    (
        .clk_sys(clk_sys), .cmd_rdata_ff(cmd_rdata_ff), .cmd_wr(cmd_wr), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .cmd_rcode(cmd_rcode), .clear_faults(clear_faults),
        .output_on_cmd(output_on_cmd)
    );
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    // the action command keeps its low byte only
    function automatic logic [15:0] exp_rd(input logic [7:0] c, input logic [15:0] d);
        return (c == ivfh_pkg::CMD_UV_ACTION) ? {8'h00, d[7:0]} : d;
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // sample held steady while its strobe crosses the synchroniser
    task automatic feed(input logic [15:0] v);
        vin_sample = v;
        vin_valid = 1'b1;
        repeat (4) @(negedge clk_sys);
        vin_valid = 1'b0;
        repeat (6) @(negedge clk_sys);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // ------------------------------------------------------------
    // restart counter and hang guard, far above the ~6200 cycles used
    // ------------------------------------------------------------
    always @(posedge clk_sys)
    begin
        cyc++;
        oe_q <= output_enable_ff;
        // count restarts and keep the spacing of the last two, in cycles
        if (output_enable_ff && !oe_q)
        begin
            rises++;
            gap = cyc - last_rise;
            last_rise = cyc;
        end
        if (cyc == 20000)
        begin
            mismatches++;
            wrap_up();
        end
    end
    initial
    begin
        sys_rst = 1'b1;
        vin_valid = 1'b0;
        vin_sample = 16'h015E; // 350, between all limits
        rng = 32'h263A1C84;
        repeat (12) @(negedge clk_sys);
        sys_rst = 1'b0;
        check(16'(output_enable_ff), 16'h0000);
        for (int i = 0; i < 4; i++)
        begin
            rng = xs(rng);
            u_host.wr(codes[i], rng[15:0]);
            u_host.rd(codes[i], rd_val);
            check(rd_val, exp_rd(codes[i], rng[15:0]));
        end
        u_host.rd(8'h5B, rd_val);
        check(rd_val, 16'h0000);
        u_host.wr(ivfh_pkg::CMD_OV_WARN, 16'h0190); // 400
        u_host.wr(ivfh_pkg::CMD_UV_WARN, 16'h012C); // 300
        u_host.wr(ivfh_pkg::CMD_UV_FAULT, 16'h0832); // 50 shifted once: 100
        u_host.wr(ivfh_pkg::CMD_TIME_UNIT, 16'h0004);
        u_host.wr(ivfh_pkg::CMD_SPECIAL, 16'h0001);
        u_host.wr(ivfh_pkg::CMD_UV_ACTION, 16'h0000);
        u_host.ctl(1'b1, 1'b0);
        feed(16'h01F4); // 500: over the warn limit
        check(16'({ov_warn_ff, uv_warn_ff, uv_fault_ff, output_enable_ff}), 16'h0009);
        feed(16'hF8B4); // 180 halved: 90, under both lower limits
        check(16'({ov_warn_ff, uv_warn_ff, uv_fault_ff, output_enable_ff}), 16'h000F);
        check(16'(hrr_low_ff), 16'h0001);
        u_host.wr(ivfh_pkg::CMD_SPECIAL, 16'h0000);
        feed(16'hF8B4);
        check(16'(hrr_low_ff), 16'h0000);
        feed(16'h015E);
        u_host.ctl(1'b1, 1'b1);
        u_host.ctl(1'b1, 1'b0);
        check(16'({ov_warn_ff, uv_warn_ff, uv_fault_ff, output_enable_ff}), 16'h0001);
        // keep running for 8 units of 4 cycles, then off with no retry
        u_host.wr(ivfh_pkg::CMD_UV_ACTION, 16'h0043);
        feed(16'hF8B4);
        check(16'(output_enable_ff), 16'h0001);
        repeat (20) @(negedge clk_sys);
        check(16'(output_enable_ff), 16'h0001);
        repeat (20) @(negedge clk_sys);
        check(16'(output_enable_ff), 16'h0000);
        feed(16'h015E);
        u_host.ctl(1'b0, 1'b0);
        u_host.ctl(1'b1, 1'b0);
        check(16'(output_enable_ff), 16'h0001);
        u_host.wr(ivfh_pkg::CMD_UV_ACTION, 16'h00C0);
        feed(16'hF8B4);
        repeat (30) @(negedge clk_sys);
        check(16'(output_enable_ff), 16'h0000);
        feed(16'h015E);
        u_host.ctl(1'b1, 1'b1);
        u_host.ctl(1'b1, 1'b0);
        check(16'(output_enable_ff), 16'h0001);
        // every retry count under disable-and-retry, random delay code
        for (int r = 0; r < 8; r++)
        begin
            rng = xs(rng);
            u_host.wr(ivfh_pkg::CMD_UV_ACTION, {8'h00, 2'h2, r[2:0], 1'b0, rng[1:0]});
            rises = 0;
            feed(16'hF8B4);
            repeat (700) @(negedge clk_sys);
            // attempts start one delay apart: unit of 4 cycles times 2^code
            if (r >= 2)
                check(16'(gap), 16'(4 << rng[1:0]));
            if (r == 7)
                check(16'(rises > 7), 16'h0001);
            else
            begin
                check(16'(rises), 16'(r));
                check(16'(output_enable_ff), 16'h0000);
            end
            feed(16'h015E);
            if (r == 7)
            begin
                // fault gone: the next attempt holds and the output stays on
                repeat (80) @(negedge clk_sys);
                check(16'(output_enable_ff), 16'h0001);
            end
            u_host.ctl(1'b0, 1'b1);
            check(16'(output_enable_ff), 16'h0000);
            u_host.ctl(1'b1, 1'b0);
        end
        wrap_up();
    end
endmodule
